// ### lcd_pin_pkg.sv
/*
   constants, field layout and carrier types of the lcd port control block.
   assumes a 32-bit ahb-lite register bus and four common drivers.
*/
`default_nettype none
package lcd_pin_pkg;
   localparam logic [31:0] CTRL_OFS       = 32'h0000_00c0;
   localparam logic [31:0] STATUS_OFS     = 32'h0000_00c4;
   localparam logic [7:0]  CTRL_RESET     = 8'h00;
   localparam int          DUTY_SEL_HI    = 7;
   localparam int          DUTY_SEL_LO    = 6;
   localparam int          COMMON_DUP     = 5;
   localparam int          EXPANSION_SEL  = 4;
   localparam int          SEG_RANGE_TOP  = 3;
   localparam int          SEG_PIN_COUNT  = 32;
   localparam int          SEG_GROUP_W    = 8;
   localparam int          COM_COUNT      = 4;
   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
   localparam logic [3:0]  RANGE_OFF      = 4'h0;

   typedef enum logic [1:0] {
      DUTY_STATIC  = 2'h0,
      DUTY_HALF    = 2'h1,
      DUTY_THIRD   = 2'h2,
      DUTY_QUARTER = 2'h3
   } duty_t;

   // phase index that each common driver follows
   typedef logic [1:0] com_phase_t;

   typedef struct packed {
      logic [SEG_PIN_COUNT-1:0] segment_pin;  // 1 = segment driver, bit 31 = top pin
      logic                     exp_en;       // top four pins carry expansion signals
      logic                     cfg_err;      // prohibited expansion/range combination
      logic [2:0]               groups;       // number of 8-pin segment groups
   } pin_cfg_t;

   typedef struct packed {
      duty_t                           duty;
      logic [COM_COUNT-1:0]            com_en;
      logic [COM_COUNT-1:0]            com_nonsel;
      com_phase_t [COM_COUNT-1:0]      com_src;
   } com_cfg_t;
endpackage
`default_nettype wire

// ### lcd_segment_duty_select.sv
/*
   lcd port control register with segment/port pin selection and common
   driver duty decoding, reached over ahb-lite.
   assumes a single ahb-lite master doing whole-word single transfers and a
   waveform generator that consumes the decoded pin and common settings.
*/
// Behaviour
// - range code 0000 or 0001 without expansion leaves all pins as ports.
// - segment function grows in 8-pin steps from the top pin downward.
// - expansion puts four external driver signals on top pins; range must be 0000.
// - duty field picks static, half, third or quarter duty on commons.
// - static duty drives common 1 only, or all four alike when duplicating.
// - half duty duplicating copies common 3 to 4 and common 1 to 2.
// - third duty duplicating drives common 4 with the non-selected waveform.
`timescale 1ns/1ps
`default_nettype none
module lcd_segment_duty_select
   import lcd_pin_pkg::*;
#(
   parameter int PIN_COUNT = SEG_PIN_COUNT
) (
   input  wire logic        core_clk,    // 40 mhz system clock
   input  wire logic        rst_b,       // asynchronous reset, active low
   input  wire logic        hsel,        // slave select
   input  wire logic [31:0] haddr,       // byte address
   input  wire logic [1:0]  htrans,      // transfer type
   input  wire logic        hwrite,      // write when high
   input  wire logic [2:0]  hsize,       // transfer size, word only
   input  wire logic [31:0] hwdata,      // write data
   input  wire logic        hready,      // bus ready
   output logic             hreadyout,   // slave ready
   output logic             hresp,       // response, always okay
   output logic [31:0]      hrdata,      // read data
   output pin_cfg_t         pin_cfg,     // decoded pin functions
   output com_cfg_t         com_cfg      // decoded common drivers
);

   if (PIN_COUNT != SEG_PIN_COUNT) begin : g_bad_pins
      $error("pin count must be 32");
   end

   ////////////////////////////////////////////////////////////////////////
   // reset synchroniser

   logic rst_meta_reg;
   logic rst_n;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // decoders

   function automatic logic [2:0] seg_groups(input logic [7:0] c);
      logic [3:0] r;
      r = c[SEG_RANGE_TOP:0];
      if (c[EXPANSION_SEL])
         seg_groups = 3'h0;
      else if (r[3])
         seg_groups = 3'h4;
      else if (r[2:1] == 2'h3)
         seg_groups = 3'h3;
      else if (r[2:1] == 2'h2)
         seg_groups = 3'h2;
      else if (r[2:1] == 2'h1)
         seg_groups = 3'h1;
      else
         seg_groups = 3'h0;
   endfunction

   function automatic pin_cfg_t decode_pins(input logic [7:0] c);
      pin_cfg_t p;
      p             = '0;
      p.groups      = seg_groups(c);
      p.exp_en      = c[EXPANSION_SEL];
      p.cfg_err     = c[EXPANSION_SEL] && (c[SEG_RANGE_TOP:0] != RANGE_OFF);
      for (int g = 0; g < SEG_PIN_COUNT / SEG_GROUP_W; g++) begin
         if (g < int'(p.groups))
            p.segment_pin[SEG_PIN_COUNT-1-g*SEG_GROUP_W -: SEG_GROUP_W] = '1;
      end
      decode_pins = p;
   endfunction

   function automatic com_cfg_t decode_com(input logic [7:0] c);
      com_cfg_t k;
      logic     dup;
      k      = '0;
      dup    = c[COMMON_DUP];
      k.duty = duty_t'({c[DUTY_SEL_HI], c[DUTY_SEL_LO]});
      unique case (k.duty)
         DUTY_STATIC: begin
            k.com_en  = dup ? 4'hf : 4'h1;
            k.com_src = '0;
         end
         DUTY_HALF: begin
            k.com_en  = dup ? 4'hf : 4'h3;
            k.com_src = dup ? {2'h1, 2'h1, 2'h0, 2'h0} : {2'h0, 2'h0, 2'h1, 2'h0};
         end
         DUTY_THIRD: begin
            k.com_en     = dup ? 4'hf : 4'h7;
            k.com_nonsel = dup ? 4'h8 : 4'h0;
            k.com_src    = {2'h0, 2'h2, 2'h1, 2'h0};
         end
         DUTY_QUARTER: begin
            k.com_en  = 4'hf;
            k.com_src = {2'h3, 2'h2, 2'h1, 2'h0};
         end
      endcase
      decode_com = k;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // ahb-lite slave

   logic       acc;
   logic       wr_ctrl_reg;
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [31:0] rd_next;
   pin_cfg_t   st_next;

   assign acc       = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         wr_ctrl_reg <= 1'b0;
      else if (hready)
         wr_ctrl_reg <= acc && hwrite && (haddr == CTRL_OFS);
   end

   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl_reg && hready)
         ctrl_next = hwdata[7:0];
   end

   // read data forwards a write completing in this cycle
   always_comb begin
      st_next = decode_pins(ctrl_next);
      rd_next = 32'h0000_0000;
      if (acc && !hwrite) begin
         if (haddr == CTRL_OFS)
            rd_next = {24'h00_0000, ctrl_next};
         else if (haddr == STATUS_OFS)
            rd_next = {27'h000_0000, st_next.cfg_err, st_next.exp_en, st_next.groups};
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         hrdata <= 32'h0000_0000;
      else if (hready)
         hrdata <= rd_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // control register and decoded outputs

   // outputs leave reset showing the decode of the reset value
   localparam pin_cfg_t PIN_RESET = decode_pins(CTRL_RESET);
   localparam com_cfg_t COM_RESET = decode_com(CTRL_RESET);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         ctrl_reg <= CTRL_RESET;
      else
         ctrl_reg <= ctrl_next;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         pin_cfg <= PIN_RESET;
      else
         pin_cfg <= decode_pins(ctrl_next);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         com_cfg <= COM_RESET;
      else
         com_cfg <= decode_com(ctrl_next);
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions

   // pin selection
   a_all_ports: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!ctrl_reg[EXPANSION_SEL] && ctrl_reg[SEG_RANGE_TOP:1] == 3'h0) |->
      (pin_cfg.segment_pin == 32'h0000_0000 && !pin_cfg.exp_en))
      else $error("pins not all ports");

   a_seg_first: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!ctrl_reg[EXPANSION_SEL] && ctrl_reg[SEG_RANGE_TOP:1] == 3'h1) |->
      pin_cfg.segment_pin == 32'hff00_0000)
      else $error("range 001x not top 8 pins");

   a_seg_steps: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!ctrl_reg[EXPANSION_SEL] && ctrl_reg[SEG_RANGE_TOP:1] == 3'h2) |->
      pin_cfg.segment_pin == 32'hffff_0000)
      else $error("range 010x not top 16 pins");

   a_seg_three: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!ctrl_reg[EXPANSION_SEL] && ctrl_reg[SEG_RANGE_TOP:1] == 3'h3) |->
      pin_cfg.segment_pin == 32'hffff_ff00)
      else $error("range 011x not top 24 pins");

   a_seg_full: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!ctrl_reg[EXPANSION_SEL] && ctrl_reg[SEG_RANGE_TOP]) |->
      (pin_cfg.segment_pin == 32'hffff_ffff && pin_cfg.groups == 3'h4))
      else $error("range 1xxx not all segments");

   a_exp_pins: assert property (@(posedge core_clk) disable iff (!rst_n)
      ctrl_reg[EXPANSION_SEL] |-> (pin_cfg.exp_en && pin_cfg.segment_pin == 32'h0000_0000
      && pin_cfg.cfg_err == (ctrl_reg[SEG_RANGE_TOP:0] != RANGE_OFF)))
      else $error("expansion pin selection wrong");

   a_status_read: assert property (@(posedge core_clk) disable iff (!rst_n)
      (acc && !hwrite && haddr == STATUS_OFS && !wr_ctrl_reg) |=> hrdata ==
      {27'h000_0000, $past(pin_cfg.cfg_err), $past(pin_cfg.exp_en), $past(pin_cfg.groups)})
      else $error("status read back wrong");

   // common drivers
   a_quarter_com: assert property (@(posedge core_clk) disable iff (!rst_n)
      (com_cfg.duty == DUTY_QUARTER) |-> (com_cfg.com_en == 4'hf && com_cfg.com_src == 8'he4
      && ctrl_reg[DUTY_SEL_HI:DUTY_SEL_LO] == 2'h3))
      else $error("quarter duty commons wrong");

   a_half_plain: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ctrl_reg[DUTY_SEL_HI:COMMON_DUP] == 3'h2) |->
      (com_cfg.com_en == 4'h3 && com_cfg.com_src == 8'h04 && com_cfg.duty == DUTY_HALF))
      else $error("half duty commons wrong");

   a_third_plain: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ctrl_reg[DUTY_SEL_HI:COMMON_DUP] == 3'h4) |->
      (com_cfg.com_en == 4'h7 && com_cfg.com_src == 8'h24 && com_cfg.duty == DUTY_THIRD))
      else $error("third duty commons wrong");

   a_static_com: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ctrl_reg[DUTY_SEL_HI:DUTY_SEL_LO] == 2'h0) |->
      (com_cfg.com_en == (ctrl_reg[COMMON_DUP] ? 4'hf : 4'h1) && com_cfg.com_src == 8'h00))
      else $error("static commons wrong");

   a_half_dup: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ctrl_reg[DUTY_SEL_HI:COMMON_DUP] == 3'h3) |->
      (com_cfg.com_en == 4'hf && com_cfg.com_src == 8'h50))
      else $error("half duty duplication wrong");

   a_third_dup: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ctrl_reg[DUTY_SEL_HI:COMMON_DUP] == 3'h5) |->
      (com_cfg.com_nonsel == 4'h8 && com_cfg.com_en == 4'hf))
      else $error("third duty common 4 not non-selected");

   a_nonsel_only: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ctrl_reg[DUTY_SEL_HI:COMMON_DUP] != 3'h5) |->
      com_cfg.com_nonsel == 4'h0)
      else $error("non-selected common outside third duty");

   // register bus
   a_write_takes: assert property (@(posedge core_clk) disable iff (!rst_n)
      (acc && hwrite && haddr == CTRL_OFS) ##1 hready |=>
      (ctrl_reg == $past(hwdata[7:0]) && pin_cfg == decode_pins($past(hwdata[7:0]))))
      else $error("write to control not applied");

   a_read_back: assert property (@(posedge core_clk) disable iff (!rst_n)
      (acc && !hwrite && haddr == CTRL_OFS && !wr_ctrl_reg) |=>
      hrdata == {24'h00_0000, $past(ctrl_reg)})
      else $error("control read back wrong");

   a_ctrl_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      !wr_ctrl_reg |=>
      $stable(ctrl_reg))
      else $error("control changed without a write");

   a_rd_unmapped: assert property (@(posedge core_clk) disable iff (!rst_n)
      (acc && !hwrite && haddr != CTRL_OFS && haddr != STATUS_OFS) |=>
      hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");

   a_hrdata_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
      (hready && !(acc && !hwrite)) |=>
      hrdata == 32'h0000_0000)
      else $error("read data not cleared after transfer");

   c_write_ctrl: cover property (@(posedge core_clk) disable iff (!rst_n)
      acc && hwrite && haddr == CTRL_OFS);
   c_expansion: cover property (@(posedge core_clk) disable iff (!rst_n) pin_cfg.exp_en);
   c_third_dup: cover property (@(posedge core_clk) disable iff (!rst_n) com_cfg.com_nonsel[3]);
   c_all_seg: cover property (@(posedge core_clk) disable iff (!rst_n) pin_cfg.groups == 3'h4);
   c_half_dup: cover property (@(posedge core_clk) disable iff (!rst_n)
      com_cfg.duty == DUTY_HALF && com_cfg.com_en == 4'hf);

endmodule // lcd_segment_duty_select
`default_nettype wire

// ### lcd_panel_model.sv
/*
   behavioural model of the lcd panel electrodes behind the shared pins.
   assumes the decoded pin and common settings of the port control block.
*/
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model
   import lcd_pin_pkg::*;
(
   input  wire pin_cfg_t    pin_cfg,     // pin functions from the block
   input  wire com_cfg_t    com_cfg,     // common drivers from the block
   output logic [5:0]       seg_driven,  // electrodes on segment drivers
   output logic [2:0]       com_driven   // commons carrying a waveform
);
   ////////////////////////////////////////////////////////////////////////
   // count live electrodes; expansion pins are never segment lines
   always_comb begin
      seg_driven = 6'($countones(pin_cfg.segment_pin));
      com_driven = 3'($countones(com_cfg.com_en));
   end
endmodule // lcd_panel_model
`default_nettype wire

// ### lcd_segment_duty_select_test.sv
/*
   self-checking bench of the lcd port control block over ahb-lite.
   assumes zero-wait-state answers and the panel model beside the block.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
   $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module lcd_segment_duty_select_test;
   import lcd_pin_pkg::*;
   logic core_clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_smp;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic        hreadyout, hresp;
   wire logic   hready = hreadyout;
   pin_cfg_t    pin_cfg;
   com_cfg_t    com_cfg;
   logic [5:0]  seg_driven;
   logic [2:0]  com_driven;
   int          n_mismatch = 0, cmp_count = 0;
   logic [7:0]  src_exp [8] = '{8'h00, 8'h00, 8'h04, 8'h50, 8'h24, 8'h24, 8'he4, 8'he4};
   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) rd_smp <= hrdata;
   lcd_segment_duty_select i_dut (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_cfg(pin_cfg), .com_cfg(com_cfg));
   lcd_panel_model i_panel (.pin_cfg(pin_cfg), .com_cfg(com_cfg), .seg_driven(seg_driven),
      .com_driven(com_driven));
   ////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge core_clk);
      while (hready !== 1'b1) begin
         n++;
         if (n > 50) begin n_mismatch++; results(); end
         @(posedge core_clk);
      end
   endtask
   task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                           output logic [31:0] rd);
      @(posedge core_clk);
      hsel <= 1'b1; haddr <= a; htrans <= HTRANS_NONSEQ; hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
      wait_rdy();
      #1 rd = rd_smp;
      `CHK({hresp, hreadyout}, 2'h1)
   endtask
   function automatic logic [31:0] seg_exp(input logic [4:0] c);
      if (c[4]) return 32'h0;
      if (c[3]) return 32'hffff_ffff;
      case (c[2:1])
         2'h1: return 32'hff00_0000;
         2'h2: return 32'hffff_0000;
         2'h3: return 32'hffff_ff00;
         default: return 32'h0;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d;
      logic [2:0]  k;
      logic [3:0]  ce;
      repeat (5) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge core_clk);
      ahb_xfer(1'b0, CTRL_OFS, 32'h0, d);
      `CHK(d, 32'h0)
      `CHK(com_cfg.com_en, 4'h1)
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         ahb_xfer(1'b1, CTRL_OFS, 32'(i), d);
         `CHK(pin_cfg.segment_pin, seg_exp(5'(i)))
         `CHK(seg_driven, 6'($countones(seg_exp(5'(i)))))
         `CHK(pin_cfg.groups, 3'($countones(seg_exp(5'(i))) / 8))
         ahb_xfer(1'b0, CTRL_OFS, 32'h0, d);
         `CHK(d, 32'(i))
         ahb_xfer(1'b0, STATUS_OFS, 32'h0, d);
         `CHK(d, 32'($countones(seg_exp(5'(i))) / 8))
      end
      $display("test ranges done");
      // variant with expansion pins present
      ahb_xfer(1'b1, CTRL_OFS, 32'h10, d);
      `CHK({pin_cfg.exp_en, pin_cfg.cfg_err, pin_cfg.segment_pin}, {2'h2, 32'h0})
      ahb_xfer(1'b1, CTRL_OFS, 32'h19, d);
      `CHK({pin_cfg.exp_en, pin_cfg.cfg_err, pin_cfg.segment_pin}, {2'h3, 32'h0})
      $display("test expansion done");
      for (int i = 0; i < 8; i++) begin
         k = 3'(i);
         ce = k[0] ? 4'hf : 4'((5'h1 << (k[2:1] + 5'h1)) - 5'h1);
         ahb_xfer(1'b1, CTRL_OFS, {24'h0, k, 5'h0}, d);
         `CHK(com_cfg.duty, duty_t'(k[2:1]))
         `CHK(com_cfg.com_en, ce)
         `CHK(com_driven, 3'($countones(ce)))
         `CHK(com_cfg.com_nonsel, (k == 3'h5) ? 4'h8 : 4'h0)
         `CHK(com_cfg.com_src, src_exp[i])
         if (k == 3'h3) `CHK(com_cfg.com_src, 8'h50)
         if (k[2:1] == 2'h3) `CHK(com_cfg.com_src, 8'he4)
      end
      $display("test duty done");
      ahb_xfer(1'b1, CTRL_OFS, 32'h0000_002a, d);
      ahb_xfer(1'b1, 32'h0000_0100, 32'h0000_00ff, d);
      ahb_xfer(1'b0, 32'h0000_0100, 32'h0, d);
      `CHK(d, 32'h0)
      ahb_xfer(1'b0, CTRL_OFS, 32'h0, d);
      `CHK(d, 32'h0000_002a)
      ahb_xfer(1'b1, CTRL_OFS, 32'hffff_ff00, d);
      ahb_xfer(1'b0, CTRL_OFS, 32'h0, d);
      `CHK(d, 32'h0)
      $display("test unmapped done");
      results();
   end
endmodule // lcd_segment_duty_select_test
`default_nettype wire
